// ### logic/sld_top.sv
// front-panel indicator driver and rotary switch decoder
`timescale 1ns/1ps
`default_nettype none
`include "sld_defs.svh"
module sld_top
  import sld_pkg::*;
#(
  parameter int TICK_CYC = `SLD_TICK_CYC,
  parameter int FLASH_TICKS = `SLD_FLASH_TICKS,
  parameter int PAUSE_TICKS = `SLD_PAUSE_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic node_ready,
  input wire logic [1:0] nmt_state,
  input wire logic err_warning,
  input wire logic guard_event,
  input wire logic guard_slave_role,
  input wire logic bus_off,
  input wire logic [3:0] node_tens_switch,
  input wire logic [3:0] node_units_switch,
  input wire logic [2:0] rate_switch,
  input wire logic termination_select_switch,
  output logic run_led,
  output logic fault_led,
  output logic term_led,
  output logic [6:0] node_id,
  output logic node_id_valid,
  output logic [9:0] bit_rate_kbps,
  output logic [2:0] bit_rate_sel
);
  // refuse timings that the 32-bit tick and 16-bit phase counters cannot hold
  if (TICK_CYC < 1 || FLASH_TICKS < 1 || PAUSE_TICKS < 1 || FLASH_TICKS > 65535
      || PAUSE_TICKS > 65535) begin : g_bad_timing
    $error("sld_top: bad timing parameters");
  end

  logic [11:0] sw_s;
  logic term_s;
  logic guard_s;
  logic guard_role_s;
  sld_sync #(.WIDTH(12)) u_sw_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({node_tens_switch, node_units_switch, rate_switch, termination_select_switch}),
    .q(sw_s)
  );
  assign term_s = sw_s[0];

  logic [31:0] tick_cnt_r;
  logic tick;
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end

  // phase timer: counts ms in current phase; phase 0..3 = on, off, on, pause
  logic [15:0] ph_cnt_r;
  logic [1:0] phase_r;
  logic blink_r;
  logic ph_end;
  logic [15:0] ph_len;
  always_comb begin
    ph_len = 16'(FLASH_TICKS);
    if (phase_r == 2'h3) begin
      ph_len = 16'(PAUSE_TICKS);
    end
  end
  assign ph_end = tick && (ph_cnt_r == ph_len - 16'h1);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_cnt_r <= '0;
      phase_r <= '0;
    end else if (ph_end) begin
      ph_cnt_r <= '0;
      phase_r <= phase_r + 2'h1;
    end else if (tick) begin
      ph_cnt_r <= ph_cnt_r + 16'h1;
    end
  end
  // blink: 200 ms on, 200 ms off from its own counter of the flash length
  logic [15:0] bl_cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bl_cnt_r <= '0;
      blink_r <= 1'b1;
    end else if (tick && bl_cnt_r == 16'(FLASH_TICKS - 1)) begin
      bl_cnt_r <= '0;
      blink_r <= ~blink_r;
    end else if (tick) begin
      bl_cnt_r <= bl_cnt_r + 16'h1;
    end
  end

  logic single_on;
  logic double_on;
  assign single_on = (phase_r == 2'h0);
  assign double_on = (phase_r == 2'h0) || (phase_r == 2'h2);

  logic [1:0] nmt_s;
  logic ready_s;
  logic warn_s;
  logic busoff_s;
  sld_sync #(.WIDTH(7)) u_st_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({nmt_state, node_ready, err_warning, guard_event, guard_slave_role, bus_off}),
    .q({nmt_s, ready_s, warn_s, guard_s, guard_role_s, busoff_s})
  );

  // a guard event from either role holds the double flash until the cycle ends
  logic guard_hold_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      guard_hold_r <= 1'b0;
    end else if (guard_s) begin
      guard_hold_r <= 1'b1;
    end else if (ph_end && phase_r == 2'h3) begin
      guard_hold_r <= 1'b0;
    end
  end

  sld_fault_pat_t fault_pat;
  always_comb begin
    if (busoff_s) begin
      fault_pat = SLD_PAT_ON;
    end else if (guard_s || guard_hold_r) begin
      fault_pat = SLD_PAT_DOUBLE;
    end else if (warn_s) begin
      fault_pat = SLD_PAT_SINGLE;
    end else begin
      fault_pat = SLD_PAT_OFF;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fault_led <= 1'b0;
    end else begin
      case (fault_pat)
        SLD_PAT_ON: fault_led <= 1'b1;
        SLD_PAT_DOUBLE: fault_led <= double_on;
        SLD_PAT_SINGLE: fault_led <= single_on;
        default: fault_led <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_led <= 1'b0;
    end else if (!ready_s) begin
      run_led <= 1'b0;
    end else begin
      case (sld_nmt_t'(nmt_s))
        SLD_NMT_STOPPED: run_led <= single_on;
        SLD_NMT_PREOP: run_led <= blink_r;
        SLD_NMT_OPER: run_led <= 1'b1;
        default: run_led <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      term_led <= 1'b0;
    end else begin
      term_led <= term_s;
    end
  end

  logic [6:0] id_nxt;
  logic digits_ok;
  assign id_nxt = 7'({3'h0, sw_s[11:8]} * 7'h0a) + 7'({3'h0, sw_s[7:4]});
  assign digits_ok = (sw_s[11:8] <= 4'h9) && (sw_s[7:4] <= 4'h9);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      node_id <= '0;
      node_id_valid <= 1'b0;
    end else begin
      node_id <= id_nxt;
      node_id_valid <= digits_ok && id_nxt >= `SLD_NODE_ID_MIN
                       && id_nxt <= `SLD_NODE_ID_MAX;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_rate_kbps <= '0;
      bit_rate_sel <= '0;
    end else begin
      bit_rate_sel <= sw_s[3:1];
      case (sw_s[3:1])
        3'h0: bit_rate_kbps <= `SLD_RATE_0;
        3'h1: bit_rate_kbps <= `SLD_RATE_1;
        3'h2: bit_rate_kbps <= `SLD_RATE_2;
        3'h3: bit_rate_kbps <= `SLD_RATE_3;
        3'h4: bit_rate_kbps <= `SLD_RATE_4;
        3'h5: bit_rate_kbps <= `SLD_RATE_5;
        3'h6: bit_rate_kbps <= `SLD_RATE_6;
        default: bit_rate_kbps <= `SLD_RATE_7;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### inc/sld_defs.svh
// timing constants and encodings for the status indicator and switch decoder
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH
`define SLD_CLK_MHZ 200
`define SLD_FLASH_MS 200
`define SLD_PAUSE_MS 1000
`define SLD_TICK_US 1000
`define SLD_TICK_CYC (`SLD_CLK_MHZ * `SLD_TICK_US)
`define SLD_FLASH_TICKS (`SLD_FLASH_MS)
`define SLD_PAUSE_TICKS (`SLD_PAUSE_MS)
`define SLD_NODE_ID_MIN 7'h01
`define SLD_NODE_ID_MAX 7'h63
`define SLD_RATE_0 10'h00a
`define SLD_RATE_1 10'h014
`define SLD_RATE_2 10'h032
`define SLD_RATE_3 10'h07d
`define SLD_RATE_4 10'h0fa
`define SLD_RATE_5 10'h1f4
`define SLD_RATE_6 10'h320
`define SLD_RATE_7 10'h3e8
`endif

// ### inc/sld_pkg.sv
// types for the status indicator and switch decoder
package sld_pkg;
  typedef enum logic [1:0] {
    SLD_NMT_INIT,
    SLD_NMT_STOPPED,
    SLD_NMT_PREOP,
    SLD_NMT_OPER
  } sld_nmt_t;
  typedef enum logic [1:0] {
    SLD_PAT_OFF,
    SLD_PAT_SINGLE,
    SLD_PAT_DOUBLE,
    SLD_PAT_ON
  } sld_fault_pat_t;
endpackage

// ### logic/sld_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sld_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### tb/sld_panel.sv
// model of the rotary switches and protocol logic feeding the decoder
`timescale 1ns/1ps
`default_nettype none
module sld_panel (
  input wire logic sys_clk,
  output logic node_ready,
  output logic [1:0] nmt_state,
  output logic err_warning,
  output logic guard_event,
  output logic bus_off,
  output logic [3:0] node_tens_switch,
  output logic [3:0] node_units_switch,
  output logic [2:0] rate_switch,
  output logic termination_select_switch
);
  initial {node_ready, nmt_state, bus_off, guard_event, err_warning} = 6'h00;
  initial {node_tens_switch, node_units_switch, rate_switch, termination_select_switch} = 12'h000;
  // ready, state, then bus-off, guard and warning flags
  task automatic net(input logic [5:0] v);
    @(negedge sys_clk);
    {node_ready, nmt_state, bus_off, guard_event, err_warning} = v;
  endtask
  // tens, units, rate position and termination switch
  task automatic sw(input logic [11:0] v);
    @(negedge sys_clk);
    {node_tens_switch, node_units_switch, rate_switch, termination_select_switch} = v;
  endtask
endmodule
`default_nettype wire

// ### tb/sld_top_checker.sv
// assertion checker for the indicator driver and switch decoder
`timescale 1ns/1ps
`default_nettype none
module sld_top_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic node_ready,
  input wire logic [1:0] nmt_state,
  input wire logic bus_off,
  input wire logic [3:0] node_tens_switch,
  input wire logic [3:0] node_units_switch,
  input wire logic [2:0] rate_switch,
  input wire logic termination_select_switch,
  input wire logic run_led,
  input wire logic fault_led,
  input wire logic term_led,
  input wire logic [6:0] node_id,
  input wire logic node_id_valid,
  input wire logic [9:0] bit_rate_kbps,
  input wire logic [2:0] bit_rate_sel
);
  logic [9:0] kb [8];
  logic [2:0] up_r;
  assign kb = '{10'h00a, 10'h014, 10'h032, 10'h07d, 10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_r <= 3'h0;
    end else if (!up_r[2]) begin
      up_r <= up_r + 3'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_term; up_r[2] |-> term_led == $past(termination_select_switch, 3); endproperty
  a_term: assert property (p_term) else $error("term led");
  property p_id;
    up_r[2] |-> node_id == 7'($past(node_tens_switch, 3) * 10 + $past(node_units_switch, 3));
  endproperty
  a_id: assert property (p_id) else $error("node id");
  property p_valid; up_r[2] |-> node_id_valid ==
    ($past(node_tens_switch, 3) < 10 && $past(node_units_switch, 3) < 10
     && ($past(node_tens_switch, 3) != 0 || $past(node_units_switch, 3) != 0));
  endproperty
  a_valid: assert property (p_valid) else $error("node id valid");
  property p_rate; up_r[2] |->
    {bit_rate_kbps, bit_rate_sel} == {kb[$past(rate_switch, 3)], $past(rate_switch, 3)};
  endproperty
  a_rate: assert property (p_rate) else $error("bit rate");
  property p_boff; up_r[2] && $past(bus_off, 3) |-> fault_led; endproperty
  a_boff: assert property (p_boff) else $error("bus off");
  property p_oper; up_r[2] && $past(node_ready, 3) && $past(nmt_state, 3) == 2'h3 |-> run_led;
  endproperty
  a_oper: assert property (p_oper) else $error("run lit");
  property p_dark;
    up_r[2] && (!$past(node_ready, 3) || $past(nmt_state, 3) == 2'h0) |-> !run_led;
  endproperty
  a_dark: assert property (p_dark) else $error("run dark");
  property p_blink; $rose(run_led) && $past(nmt_state, 3) == 2'h2 && $past(nmt_state, 11) == 2'h2
    |-> run_led [*8] ##1 (!run_led || $past(nmt_state, 3) != 2'h2);
  endproperty
  a_blink: assert property (p_blink) else $error("blink on time");
endmodule
bind sld_top sld_top_checker chk_u (.*);
`default_nettype wire

// ### tb/tb_top.sv
// self-checking testbench for the indicator driver and switch decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic guard_slave_role = 1'b1;
  logic node_ready, err_warning, guard_event, bus_off, termination_select_switch;
  logic [1:0] nmt_state;
  logic [3:0] node_tens_switch, node_units_switch;
  logic [2:0] rate_switch, bit_rate_sel;
  logic run_led, fault_led, term_led, node_id_valid;
  logic [6:0] node_id;
  logic [9:0] bit_rate_kbps;
  logic [15:0] r, f;
  int mismatches = 0;
  int compares = 0;
  localparam logic [3:0] tt [8] = '{4'h3, 4'h9, 4'h0, 4'h0, 4'h1, 4'ha, 4'h9, 4'h5};
  localparam logic [3:0] uu [8] = '{4'h2, 4'h9, 4'h0, 4'h1, 4'h0, 4'h0, 4'ha, 4'h7};
  localparam logic [9:0] kb [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d, 10'h0fa, 10'h1f4,
    10'h320, 10'h3e8};
  localparam logic [5:0] nv [6] = '{6'h18, 6'h29, 6'h32, 6'h3f, 6'h23, 6'h38};
  localparam logic [7:0] er [6] = '{8'h00, 8'h20, 8'h58, 8'hb0, 8'h00, 8'hb0};
  localparam logic [7:0] ef [6] = '{8'h00, 8'h20, 8'h40, 8'hb0, 8'h40, 8'h00};
  sld_panel pm_u (.*);
  sld_top #(.TICK_CYC(4), .FLASH_TICKS(2), .PAUSE_TICKS(5)) dut_u (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #30us;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pm_u.sw({tt[i], uu[i], i[2:0], i[0]});
      repeat (4) @(posedge sys_clk);
      #1;
      chk(node_id, tt[i] * 10 + uu[i]);
      chk(node_id_valid, tt[i] < 10 && uu[i] < 10 && tt[i] + uu[i] > 0);
      chk(bit_rate_kbps, kb[i]);
      chk(bit_rate_sel, i);
      chk(term_led, i[0]);
    end
    $display("test switches done");
    for (int i = 0; i < 6; i++) begin
      pm_u.net(nv[i]);
      guard_slave_role = i[2];
      repeat (48) @(posedge sys_clk);
      r = 16'h0000;
      f = 16'h0000;
      repeat (176) begin
        @(posedge sys_clk);
        #1;
        r += run_led;
        f += fault_led;
      end
      chk(r, er[i]);
      chk(f, ef[i]);
    end
    $display("test leds done");
    stop_test();
  end
endmodule
`default_nettype wire
